// [pkg/imce_pkg.sv]
// Shared constants and types of the two-wire master command engine.
package imce_pkg;
  localparam int IDX_W = 12;
  localparam int CNT_W = 12;
  localparam int DATA_W = 16;
  localparam int MEM_DEPTH = 4096;
  localparam int ADDR_W = 7;
  localparam int LINK_CLK_NS = 125;
  localparam int BUS_KHZ = 100;
  localparam int QTR_NS = 1000000 / (4 * BUS_KHZ);
  localparam int QTR_CYC = QTR_NS / LINK_CLK_NS;
  localparam int QCNT_W = 8;
  localparam logic [QCNT_W-1:0] QTR_LAST = QCNT_W'(QTR_CYC - 1);
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] PH_LAST = 2'h3;

  typedef enum logic [1:0] {
    IMCE_OP_WRITE,
    IMCE_OP_READ,
    IMCE_OP_STOP
  } imce_op_t;

  typedef struct packed {
    imce_op_t op;
    logic [ADDR_W-1:0] target_address;
    logic [IDX_W-1:0] start;
    logic [CNT_W-1:0] count;
  } imce_cmd_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [7:0] data;
  } imce_rx_t;
endpackage

// [hdl/imce_word_mem.sv]
// Word buffer memory: one write port and a read port on each clock.
`timescale 1ns/1ps
module imce_word_mem #(
  parameter int DEPTH = imce_pkg::MEM_DEPTH,
  parameter int AW = imce_pkg::IDX_W,
  parameter int DW = imce_pkg::DATA_W
) (
  input wire logic clk_a_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_a_addr_i,
  output logic [DW-1:0] rd_a_data_o,
  input wire logic clk_b_i,
  input wire logic [AW-1:0] rd_b_addr_i,
  output logic [DW-1:0] rd_b_data_o
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_a_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_a_data_o <= mem[rd_a_addr_i];
  end

  // The link side only reads, so the array has a single writer.
  always_ff @(posedge clk_b_i) begin
    rd_b_data_o <= mem[rd_b_addr_i];
  end
endmodule

// [hdl/imce_engine.sv]
// Two-wire bus master that runs write, read and stop commands on a word buffer.
`timescale 1ns/1ps
module imce_engine #(
  parameter int DEPTH = imce_pkg::MEM_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_link_i,
  input wire logic cmd_valid_i,
  input wire imce_pkg::imce_cmd_t cmd_i,
  output logic cmd_ready_o,
  output logic cmd_done_o,
  output logic cmd_ack_o,
  input wire logic mem_wr_i,
  input wire logic [imce_pkg::IDX_W-1:0] mem_addr_i,
  input wire logic [imce_pkg::DATA_W-1:0] mem_wdata_i,
  output logic [imce_pkg::DATA_W-1:0] mem_rdata_o,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_HELD, ST_START, ST_BIT, ST_STOP} imce_state_t;
  function automatic logic [imce_pkg::IDX_W-1:0] idx_add(
    input logic [imce_pkg::IDX_W-1:0] base,
    input logic [imce_pkg::CNT_W-1:0] off
  );
    idx_add = base + imce_pkg::IDX_W'(off);
  endfunction
  // ---------------- System clock domain ----------------
  imce_pkg::imce_cmd_t cmd_ff, nxt_cmd;
  logic busy_ff, nxt_busy, req_tgl_ff, nxt_req_tgl, done_ff, nxt_done, ack_ff, nxt_ack;
  logic [2:0] dsync_ff, rsync_ff;
  imce_pkg::imce_rx_t rx_ff, nxt_rx;
  logic done_tgl_ff, rx_tgl_ff, ack_res_ff;
  logic done_seen, rx_seen;
  logic [imce_pkg::DATA_W-1:0] mem_b_data;
  logic [imce_pkg::CNT_W-1:0] off_ff, nxt_off;
  assign done_seen = dsync_ff[1] ^ dsync_ff[2];
  assign rx_seen = rsync_ff[1] ^ rsync_ff[2];
  always_comb begin
    nxt_cmd = cmd_ff;
    nxt_busy = busy_ff;
    nxt_req_tgl = req_tgl_ff;
    nxt_done = 1'b0;
    nxt_ack = ack_ff;
    if (!busy_ff && cmd_valid_i) begin
      nxt_cmd = cmd_i;
      nxt_busy = 1'b1;
      nxt_req_tgl = ~req_tgl_ff;
    end else if (busy_ff && done_seen) begin
      nxt_busy = 1'b0;
      nxt_done = 1'b1;
      // The link result changes no later than its done toggle, which still has to cross the synchronizer, so it is safe to sample.
      nxt_ack = ack_res_ff;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ff <= '0;
      busy_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      done_ff <= 1'b0;
      ack_ff <= 1'b0;
      dsync_ff <= 3'h0;
      rsync_ff <= 3'h0;
    end else begin
      cmd_ff <= nxt_cmd;
      busy_ff <= nxt_busy;
      req_tgl_ff <= nxt_req_tgl;
      done_ff <= nxt_done;
      ack_ff <= nxt_ack;
      dsync_ff <= {dsync_ff[1:0], done_tgl_ff};
      rsync_ff <= {rsync_ff[1:0], rx_tgl_ff};
    end
  end
  assign cmd_ready_o = ~busy_ff;
  assign cmd_done_o = done_ff;
  assign cmd_ack_o = ack_ff;
  // A received byte takes the write port; a user write in that same cycle is lost.
  imce_word_mem #(
    .DEPTH(DEPTH)
  ) u_mem (
    .clk_a_i(clk_sys_i),
    .wr_en_i(rx_seen | mem_wr_i),
    .wr_addr_i(rx_seen ? rx_ff.idx : mem_addr_i),
    .wr_data_i(rx_seen ? imce_pkg::DATA_W'(rx_ff.data) : mem_wdata_i),
    .rd_a_addr_i(mem_addr_i),
    .rd_a_data_o(mem_rdata_o),
    .clk_b_i(clk_link_i),
    .rd_b_addr_i(idx_add(cmd_ff.start, off_ff)),
    .rd_b_data_o(mem_b_data)
  );

  // ---------------- Link clock domain ----------------
  imce_state_t st_ff, nxt_st;
  logic [imce_pkg::QCNT_W-1:0] qcnt_ff, nxt_qcnt;
  logic [1:0] ph_ff, nxt_ph;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic addr_ph_ff, nxt_addr_ph, rd_ff, nxt_rd, acked_ff, nxt_acked;
  logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
  logic nxt_ack_res, nxt_done_tgl, nxt_rx_tgl;
  logic [2:0] lreq_ff;
  logic [1:0] sda_s_ff;
  logic tick, tx, last, drive_low;
  assign tick = (qcnt_ff == '0);
  assign tx = addr_ph_ff | ~rd_ff;
  assign last = (off_ff == cmd_ff.count - imce_pkg::CNT_W'(1));
  // Data bits drive the shifted byte when sending; the ninth bit acknowledges each read byte but the last.
  assign drive_low = (bit_ff == imce_pkg::ACK_BIT) ? (~tx & ~last) : (tx & ~sh_ff[7]);
  always_comb begin
    nxt_st = st_ff;
    nxt_qcnt = tick ? imce_pkg::QTR_LAST : qcnt_ff - imce_pkg::QCNT_W'(1);
    nxt_ph = ph_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_off = off_ff;
    nxt_addr_ph = addr_ph_ff;
    nxt_rd = rd_ff;
    nxt_acked = acked_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_ack_res = ack_res_ff;
    nxt_done_tgl = done_tgl_ff;
    nxt_rx_tgl = rx_tgl_ff;
    nxt_rx = rx_ff;
    case (st_ff)
      ST_IDLE, ST_HELD: begin
        if (lreq_ff[1] ^ lreq_ff[2]) begin
          nxt_qcnt = imce_pkg::QTR_LAST;
          nxt_ph = 2'h0;
          if (cmd_ff.op == imce_pkg::IMCE_OP_STOP) begin
            nxt_st = ST_STOP;
          end else begin
            nxt_st = ST_START;
            nxt_rd = (cmd_ff.op == imce_pkg::IMCE_OP_READ);
            nxt_addr_ph = 1'b1;
            nxt_off = '0;
          end
        end
      end
      ST_START: begin
        // Works from idle and, with the clock held low, as a repeated start.
        if (tick) begin
          nxt_ph = ph_ff + 2'h1;
          case (ph_ff)
            2'h0: nxt_sda_oe = 1'b0;
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_sda_oe = 1'b1;
            default: begin
              nxt_scl_oe = 1'b1;
              nxt_sh = {cmd_ff.target_address, rd_ff};
              nxt_bit = 4'h0;
              nxt_st = ST_BIT;
            end
          endcase
        end
      end
      ST_BIT: begin
        if (tick) begin
          nxt_ph = ph_ff + 2'h1;
          case (ph_ff)
            2'h0: nxt_sda_oe = drive_low;
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: begin
              if (bit_ff == imce_pkg::ACK_BIT) begin
                nxt_acked = ~sda_s_ff[1];
              end else begin
                nxt_sh = {sh_ff[6:0], sda_s_ff[1]};
              end
            end
            default: begin
              nxt_scl_oe = 1'b1;
              nxt_bit = bit_ff + 4'h1;
              if (bit_ff == imce_pkg::ACK_BIT) begin
                nxt_bit = 4'h0;
                // Keep SDA until the next quarter so it never moves with the falling SCL.
                if (addr_ph_ff) begin
                  nxt_ack_res = acked_ff;
                  nxt_addr_ph = 1'b0;
                  if (!acked_ff) begin
                    nxt_st = ST_STOP;
                  end else if (cmd_ff.count == '0) begin
                    nxt_st = rd_ff ? ST_STOP : ST_HELD;
                    nxt_done_tgl = rd_ff ? done_tgl_ff : ~done_tgl_ff;
                  end else if (!rd_ff) begin
                    nxt_sh = mem_b_data[7:0];
                    nxt_off = off_ff + imce_pkg::CNT_W'(1);
                  end
                end else if (!rd_ff) begin
                  if (!acked_ff) begin
                    nxt_ack_res = 1'b0;
                    nxt_st = ST_STOP;
                  end else if (off_ff == cmd_ff.count) begin
                    nxt_st = ST_HELD;
                    nxt_done_tgl = ~done_tgl_ff;
                  end else begin
                    nxt_sh = mem_b_data[7:0];
                    nxt_off = off_ff + imce_pkg::CNT_W'(1);
                  end
                end else begin
                  nxt_rx.idx = idx_add(cmd_ff.start, off_ff);
                  nxt_rx.data = sh_ff;
                  nxt_rx_tgl = ~rx_tgl_ff;
                  nxt_off = off_ff + imce_pkg::CNT_W'(1);
                  if (last) begin
                    nxt_st = ST_STOP;
                  end
                end
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          nxt_ph = ph_ff + 2'h1;
          case (ph_ff)
            2'h0: nxt_sda_oe = 1'b1;
            2'h1: nxt_scl_oe = 1'b0;
            2'h2: nxt_sda_oe = 1'b0;
            default: begin
              nxt_st = ST_IDLE;
              nxt_done_tgl = ~done_tgl_ff;
            end
          endcase
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_link_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      qcnt_ff <= imce_pkg::QTR_LAST;
      ph_ff <= 2'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      off_ff <= '0;
      addr_ph_ff <= 1'b0;
      rd_ff <= 1'b0;
      acked_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ack_res_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
      rx_tgl_ff <= 1'b0;
      rx_ff <= '0;
      lreq_ff <= 3'h0;
      sda_s_ff <= 2'h0;
    end else begin
      st_ff <= nxt_st;
      qcnt_ff <= nxt_qcnt;
      ph_ff <= nxt_ph;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      off_ff <= nxt_off;
      addr_ph_ff <= nxt_addr_ph;
      rd_ff <= nxt_rd;
      acked_ff <= nxt_acked;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      ack_res_ff <= nxt_ack_res;
      done_tgl_ff <= nxt_done_tgl;
      rx_tgl_ff <= nxt_rx_tgl;
      rx_ff <= nxt_rx;
      lreq_ff <= {lreq_ff[1:0], req_tgl_ff};
      sda_s_ff <= {sda_s_ff[0], sda_i};
    end
  end

  // Open drain: the pins only ever pull low, so the driven level is a constant zero.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_oe_ff;
  assign sda_oe_o = sda_oe_ff;
endmodule

// [sim/imce_engine_sva.sv]
// Port-level assertions for the two-wire master command engine.
`timescale 1ns/1ps
module imce_engine_sva (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_link_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic cmd_done_o,
  input wire logic cmd_ack_o,
  input wire logic mem_wr_i,
  input wire logic [imce_pkg::IDX_W-1:0] mem_addr_i,
  input wire logic [imce_pkg::DATA_W-1:0] mem_wdata_i,
  input wire logic [imce_pkg::DATA_W-1:0] mem_rdata_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  localparam int HALF = 2 * imce_pkg::QTR_CYC;
  logic [7:0] hi_ff;
  logic [7:0] nxt_hi;
  // Saturates so that an idle bus followed by a START never looks like a clock pulse.
  always_comb begin
    nxt_hi = scl_oe_o ? 8'h00 : ((hi_ff == 8'hff) ? hi_ff : hi_ff + 8'h01);
  end
  always_ff @(posedge clk_link_i or posedge rst_i) begin
    if (rst_i) begin
      hi_ff <= 8'hff;
    end else begin
      hi_ff <= nxt_hi;
    end
  end
  a_done_one_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cmd_done_o |=> !cmd_done_o) else $error("done pulse longer than one cycle");
  a_take_drops_ready: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cmd_valid_i && cmd_ready_o |=> !cmd_ready_o) else $error("ready stayed after take");
  a_done_sets_ready: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cmd_done_o |-> ##[0:1] cmd_ready_o) else $error("ready missing after done");
  a_ack_only_done: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !cmd_done_o |-> $stable(cmd_ack_o)) else $error("result moved without done");
  a_open_drain: assert property (@(posedge clk_link_i) disable iff (rst_i)
    !scl_o && !sda_o) else $error("bus line driven high");
  a_scl_half_period: assert property (@(posedge clk_link_i) disable iff (rst_i)
    $rose(scl_oe_o) && hi_ff < 8'h3c |-> hi_ff == 8'(HALF)) else $error("clock high time wrong");
  a_stop_ends_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(sda_oe_o) && !scl_oe_o |-> ##[1:400] cmd_done_o) else $error("no done after stop");
  a_mem_read_back: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mem_wr_i ##1 (mem_addr_i == $past(mem_addr_i)) |=> mem_rdata_o == $past(mem_wdata_i, 2))
    else $error("buffer read back differs");
endmodule
bind imce_engine imce_engine_sva u_sva (.clk_sys_i, .rst_i, .clk_link_i, .cmd_valid_i,
  .cmd_ready_o, .cmd_done_o, .cmd_ack_o, .mem_wr_i, .mem_addr_i, .mem_wdata_i, .mem_rdata_o,
  .scl_o, .scl_oe_o, .sda_o, .sda_oe_o);

// [sim/imce_slave_model.sv]
// Behavioural two-wire slave that stores written bytes and serves a counting pattern.
`timescale 1ns/1ps
module imce_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o
);
  logic [7:0] sh, tx, hdr_b;
  logic [7:0] rx_q[$];
  logic act = 0, hdr = 0, sel = 0, rd = 0, smp = 0;
  int bitn = 0, nstop = 0, nrd = 0;
  initial sda_oe_o = 0;
  // The clock fall that ends a START lifts bitn to zero without shifting.
  always @(negedge sda_i) begin
    if (scl_i) begin
      act = 1;
      hdr = 1;
      sel = 0;
      bitn = -1;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i && act) begin
      act = 0;
      nstop++;
    end
  end
  always @(posedge scl_i) begin
    smp = sda_i;
  end
  always @(negedge scl_i) begin
    if (act) begin
      sda_oe_o = 0;
      bitn = (bitn == 8) ? 0 : bitn + 1;
      if (bitn > 0) begin
        sh = {sh[6:0], smp};
      end
      if (bitn == 8 && hdr) begin
        hdr_b = sh;
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
        hdr = 0;
        nrd = 0;
        sda_oe_o = sel;
      end else if (bitn == 8 && sel && !rd) begin
        rx_q.push_back(sh);
        sda_oe_o = 1;
      end else if (bitn < 8 && sel && rd) begin
        if (bitn == 0 && smp) begin
          sel = 0;
        end else begin
          if (bitn == 0) begin
            tx = 8'h3c + 8'(nrd);
            nrd++;
          end
          sda_oe_o = !tx[7 - bitn];
        end
      end
    end
  end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the command engine against the behavioural slave.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module tb_top;
  logic clk_sys_i = 0, clk_link_i = 0, rst_i = 1, cmd_valid_i = 0, mem_wr_i = 0;
  imce_pkg::imce_cmd_t cmd_i = '0;
  logic [imce_pkg::IDX_W-1:0] mem_addr_i = '0;
  logic [imce_pkg::DATA_W-1:0] mem_wdata_i = '0;
  logic [imce_pkg::DATA_W-1:0] mem_rdata_o;
  logic cmd_ready_o, cmd_done_o, cmd_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, s_oe;
  wire logic scl_w = !scl_oe_o;
  wire logic sda_w = !(sda_oe_o || s_oe);
  int n_fail = 0, checks = 0, cyc = 0;
  logic [7:0] d[2];
  logic [11:0] st, n, rn;
  imce_engine u_dut (.clk_sys_i, .rst_i, .clk_link_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
    .cmd_done_o, .cmd_ack_o, .mem_wr_i, .mem_addr_i, .mem_wdata_i, .mem_rdata_o, .scl_o,
    .scl_oe_o, .sda_i(sda_w), .sda_o, .sda_oe_o);
  imce_slave_model #(.ADDR(7'h50)) u_slv (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(s_oe));
  initial begin
    forever #5 clk_sys_i = !clk_sys_i;
  end
  initial begin
    #17;
    forever #62.5 clk_link_i = !clk_link_i;
  end
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // The run needs about 80000 cycles; the margin covers crossing slack.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic mw(input logic [11:0] a, input logic [15:0] v);
    @(negedge clk_sys_i);
    mem_wr_i = 1;
    mem_addr_i = a;
    mem_wdata_i = v;
    @(negedge clk_sys_i);
    mem_wr_i = 0;
  endtask
  task automatic mr(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    mem_addr_i = a;
    @(negedge clk_sys_i);
    `CHK("buffer word", e, mem_rdata_o[7:0])
  endtask
  task automatic run(input imce_pkg::imce_op_t op, input logic [6:0] a, input logic [11:0] s,
      input logic [11:0] c);
    @(negedge clk_sys_i);
    cmd_i = '{op, a, s, c};
    cmd_valid_i = 1;
    @(negedge clk_sys_i);
    cmd_valid_i = 0;
    while (cmd_done_o !== 1'b1) @(negedge clk_sys_i);
  endtask
  initial begin
    void'($urandom(32'ha8a9));
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 0;
    `CHK("clock line", 1'b0, scl_oe_o)
    st = 12'($urandom_range(4000));
    n = 12'($urandom_range(2, 1));
    for (int i = 0; i < 2; i++) begin
      d[i] = 8'($urandom);
      mw(st + 12'(i), {8'h00, d[i]});
    end
    mr(st, d[0]);
    run(imce_pkg::IMCE_OP_WRITE, 7'h50, st, n);
    `CHK("header", {7'h50, 1'b0}, u_slv.hdr_b)
    `CHK("ack", 1'b1, cmd_ack_o)
    `CHK("bytes", 32'(n), u_slv.rx_q.size())
    for (int i = 0; i < n; i++) `CHK("byte", d[i], u_slv.rx_q[i])
    `CHK("clock held", 1'b1, scl_oe_o)
    `CHK("stops", 0, u_slv.nstop)
    rn = st + 12'h2;
    mw(rn + 12'h2, 16'h00a5);
    run(imce_pkg::IMCE_OP_READ, 7'h50, rn, 12'h2);
    `CHK("header", {7'h50, 1'b1}, u_slv.hdr_b)
    `CHK("ack", 1'b1, cmd_ack_o)
    `CHK("stops", 1, u_slv.nstop)
    `CHK("pattern count", 2, u_slv.nrd)
    for (int i = 0; i < 2; i++) mr(rn + 12'(i), 8'h3c + 8'(i));
    mr(rn + 12'h2, 8'ha5);
    run(imce_pkg::IMCE_OP_WRITE, 7'h50, st, 12'h0);
    `CHK("clock held", 1'b1, scl_oe_o)
    run(imce_pkg::IMCE_OP_STOP, 7'h00, 12'h0, 12'h0);
    `CHK("stops", 2, u_slv.nstop)
    `CHK("clock free", 1'b0, scl_oe_o)
    u_slv.rx_q.delete();
    run(imce_pkg::IMCE_OP_WRITE, 7'h22, st, 12'h1);
    `CHK("ack", 1'b0, cmd_ack_o)
    `CHK("bytes", 0, u_slv.rx_q.size())
    `CHK("stops", 3, u_slv.nstop)
    conclude();
  end
endmodule
